// ===== rtl/ubds_pkg.sv
// package: register map, descriptor status layout, engine states and stream carriers
package ubds_pkg;
    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADDR_BD_STATUS = 8'h00;
    localparam logic [7:0] ADDR_ENGINE = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    // ****************************************************************
    // descriptor status byte fields
    // ****************************************************************
    localparam int OWN_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int CHECK_BIT = 3;
    localparam int STALL_BIT = 2;
    localparam logic [7:0] BD_STATUS_RESET = 8'h00;
    localparam int FIFO_DEPTH = 8;
    localparam int DATA_W = 8;

    // ****************************************************************
    // handshake answers and engine states
    // ****************************************************************
    typedef enum logic [1:0] {
        UBDS_HS_ACK = 2'h0,
        UBDS_HS_NAK = 2'h1,
        UBDS_HS_STALL = 2'h2,
        UBDS_HS_NONE = 2'h3
    } ubds_hs_t;

    typedef enum logic [2:0] {
        UBDS_IDLE = 3'b001,
        UBDS_DATA = 3'b010,
        UBDS_DONE = 3'b100
    } ubds_state_t;

    typedef struct packed {
        logic in_dir;
        logic pid_data1;
    } ubds_token_t;

    typedef struct packed {
        logic last;
        logic [DATA_W-1:0] data;
    } ubds_beat_t;
endpackage

// ===== rtl/ubds_fifo.sv
// buffer fifo: its module stands beside the engine logic in ubds_engine.sv

// ===== rtl/ubds_engine.sv
// descriptor status handling for one endpoint buffer, with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - owner 1: engine uses descriptor for tokens
// - owner 0: engine ignores other fields
// - toggle flag records DATA1 as 1, DATA0 as 0
// - reserved bits undefined; logic ignores them
// - toggle checked only when check enable 1
// - mismatched toggle packet discarded, buffer fifo flushed of undrained beats
// - stall flag set: answer token with STALL
// - stalled token leaves descriptor unchanged, still owned
// - finished token clears owner flag
module ubds_engine
    import ubds_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // link side: decoded token, packet beats, handshake answer
    input wire logic token_valid,
    input wire ubds_token_t token,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire ubds_beat_t rx_beat,
    output logic hs_valid,
    output ubds_hs_t hs_code,
    // buffer side: accepted packet data drains here
    output logic buf_valid,
    input wire logic buf_ready,
    output ubds_beat_t buf_beat
);
    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0] bd_status;
    ubds_state_t state;
    logic tok_in;
    logic tok_pid;
    logic pkt_bad;
    logic [7:0] pkt_count;
    logic flush;
    logic fifo_in_ready;
    logic accept_ok;

    function automatic logic toggle_ok(input logic [7:0] st, input logic pid);
        // reserved bits 5:4 and 1:0 never looked at
        return !st[CHECK_BIT] || (st[TOGGLE_BIT] == pid);
    endfunction

    // ****************************************************************
    // axi4-lite write path
    // ****************************************************************
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic fw_bd_write;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign s_axi_bresp = 2'h0;
    // firmware may only rewrite the status byte it owns
    assign fw_bd_write = wr_fire && aw_addr == ADDR_BD_STATUS && w_strb[0]
        && !bd_status[OWN_BIT];

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // axi4-lite read path
    // ****************************************************************
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp = 2'h0;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            unique case (s_axi_araddr)
                ADDR_BD_STATUS: s_axi_rdata <= {24'h000000, bd_status};
                ADDR_ENGINE: s_axi_rdata <= {29'h0, state};
                ADDR_COUNT: s_axi_rdata <= {24'h000000, pkt_count};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // token engine
    // ****************************************************************
    logic tok_use;
    logic tok_stall;
    logic rx_take;
    logic last_take;

    // a token only uses the descriptor while the engine owns it
    assign tok_use = token_valid && state == UBDS_IDLE && bd_status[OWN_BIT];
    assign tok_stall = tok_use && bd_status[STALL_BIT];
    assign rx_ready = (state == UBDS_DATA) && (fifo_in_ready || pkt_bad);
    assign rx_take = rx_valid && rx_ready;
    assign last_take = rx_take && rx_beat.last;
    assign accept_ok = (state == UBDS_DONE) && !pkt_bad;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state <= UBDS_IDLE;
            tok_in <= 1'b0;
            tok_pid <= 1'b0;
            pkt_bad <= 1'b0;
        end else begin
            unique case (state)
                UBDS_IDLE: begin
                    if (tok_use && !tok_stall) begin
                        tok_in <= token.in_dir;
                        tok_pid <= token.pid_data1;
                        // out packets with wrong toggle are dropped, not buffered
                        pkt_bad <= !token.in_dir && !toggle_ok(bd_status, token.pid_data1);
                        state <= token.in_dir ? UBDS_DONE : UBDS_DATA;
                    end
                end
                UBDS_DATA: begin
                    if (last_take) begin
                        state <= UBDS_DONE;
                    end
                end
                UBDS_DONE: begin
                    state <= UBDS_IDLE;
                end
            endcase
        end
    end

    // handshake answer, one cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            hs_valid <= 1'b0;
            hs_code <= UBDS_HS_NONE;
        end else begin
            hs_valid <= 1'b0;
            if (token_valid && state == UBDS_IDLE) begin
                hs_valid <= 1'b1;
                hs_code <= tok_stall ? UBDS_HS_STALL : UBDS_HS_NAK;
                if (tok_use && !tok_stall) begin
                    hs_valid <= 1'b0;
                end
            end else if (state == UBDS_DONE) begin
                hs_valid <= 1'b1;
                hs_code <= pkt_bad ? UBDS_HS_NONE : UBDS_HS_ACK;
            end
        end
    end

    // ****************************************************************
    // descriptor status byte
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            bd_status <= BD_STATUS_RESET;
        end else if (accept_ok) begin
            // owner release and toggle record in one update
            bd_status[OWN_BIT] <= 1'b0;
            bd_status[TOGGLE_BIT] <= tok_pid;
        end else if (fw_bd_write) begin
            // the owner bit arrives with this byte, so other fields land in the same write
            bd_status <= w_data[7:0];
        end
        // a stalled token never reaches accept_ok: byte kept as is
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pkt_count <= 8'h00;
        end else if (accept_ok) begin
            pkt_count <= pkt_count + 8'h01;
        end
    end

    // discarded packet data must not reach the buffer
    assign flush = (state == UBDS_DONE) && pkt_bad && !tok_in;

    ubds_fifo #(
        .WIDTH(DATA_W + 1),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .flush(flush),
        .in_valid(rx_valid && state == UBDS_DATA && !pkt_bad),
        .in_ready(fifo_in_ready),
        .in_data(rx_beat),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_beat)
    );
endmodule // ubds_engine

// ****************************************************************
// buffer fifo
// ****************************************************************
module ubds_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    // one bit wider than the pointers so full and empty differ
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // ubds_fifo
`default_nettype wire

// ===== sim/ubds_chk.sv
// port checker for the descriptor status engine
`timescale 1ns/1ps
`default_nettype none
module ubds_chk
    import ubds_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic token_valid,
    input wire ubds_token_t token,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire ubds_beat_t rx_beat,
    input wire logic hs_valid,
    input wire ubds_hs_t hs_code
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // ********
    // properties
    // ********
    a_hs_pulse: assert property (hs_valid |=> !hs_valid)
        else $error("handshake pulse too long");
    a_tok_answer: assert property (token_valid && token.in_dir |-> ##[1:2] hs_valid)
        else $error("token left unanswered");
    a_out_answer: assert property (rx_valid && rx_ready && rx_beat.last |-> ##[1:3] hs_valid)
        else $error("packet left unanswered");
    a_ack_cause: assert property (hs_valid && hs_code == UBDS_HS_ACK |->
        $past(token_valid, 2) || $past(rx_valid && rx_ready && rx_beat.last, 2))
        else $error("ack without a finished token");
    a_quick_refusal: assert property (hs_valid && hs_code inside {UBDS_HS_NAK, UBDS_HS_STALL}
        |-> $past(token_valid))
        else $error("nak or stall late");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken while response pending");
    a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    c_stall: cover property (hs_valid && hs_code == UBDS_HS_STALL);
    c_drop: cover property (hs_valid && hs_code == UBDS_HS_NONE);
    c_ack: cover property (hs_valid && hs_code == UBDS_HS_ACK);
endmodule // ubds_chk
bind ubds_engine ubds_chk chk (.*);
`default_nettype wire

// ===== sim/ubds_host.sv
// usb host stand-in: sends tokens and packet beats, records handshakes
`timescale 1ns/1ps
`default_nettype none
module ubds_host
    import ubds_pkg::*;
(
    input wire logic clk_sys,
    output logic token_valid,
    output ubds_token_t token,
    output logic rx_valid,
    input wire logic rx_ready,
    output ubds_beat_t rx_beat,
    input wire logic hs_valid,
    input wire ubds_hs_t hs_code
);
    int hs_cnt = 0;
    ubds_hs_t hs_last = UBDS_HS_NONE;
    initial {token_valid, token, rx_valid, rx_beat} = '0;
    always @(posedge clk_sys) begin
        if (hs_valid) begin
            hs_cnt <= hs_cnt + 1;
            hs_last <= hs_code;
        end
    end
    task automatic tok(input logic in_dir, input logic pid);
        @(posedge clk_sys);
        token_valid <= 1'b1;
        token <= {in_dir, pid};
        @(posedge clk_sys);
        token_valid <= 1'b0;
        token <= ~token; // stale token never lingers
    endtask
    task automatic pkt(input int n, input logic [7:0] b, input logic slow);
        for (int i = 0; i < n; i++) begin
            rx_valid <= 1'b1;
            rx_beat <= {i == n - 1, b + 8'(i)};
            @(posedge clk_sys iff rx_ready);
            if (slow || i == n - 1) begin
                rx_valid <= 1'b0;
                rx_beat <= ~rx_beat;
                if (slow) @(posedge clk_sys);
            end
        end
    endtask
endmodule // ubds_host
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the descriptor status engine
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ubds_pkg::*;
;
    logic clk_sys, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic token_valid, rx_valid, rx_ready, hs_valid, buf_valid, buf_ready, hold_buf;
    logic [7:0] s_axi_awaddr, s_axi_araddr, cur;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    ubds_token_t token;
    ubds_beat_t rx_beat, buf_beat;
    ubds_hs_t hs_code;
    int error_cnt = 0, checked = 0, cyc = 0, n_pkt = 0;
    logic [7:0] got_q[$];
    ubds_engine dut (.*);
    ubds_host host (.*);
    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        buf_ready <= hold_buf ? 1'b0 : 1'($urandom); // drain side stalls at random
        if (rst_b && buf_valid && buf_ready) got_q.push_back(buf_beat.data);
        if (cyc == 20000) begin
            error_cnt++;
            $display("[ERR] %0t timeout", $time);
            end_of_test();
        end
    end
    // bready and rready stay high: always ready for an answer
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        fork
            @(posedge clk_sys iff s_axi_awready) s_axi_awvalid <= 1'b0;
            @(posedge clk_sys iff s_axi_wready) s_axi_wvalid <= 1'b0;
        join
        @(posedge clk_sys iff s_axi_bvalid) chk(32'(s_axi_bresp), 32'h0);
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        @(posedge clk_sys iff s_axi_arready) s_axi_arvalid <= 1'b0;
        @(posedge clk_sys iff s_axi_rvalid) begin
            chk(s_axi_rdata & m, exp);
            chk(32'(s_axi_rresp), 32'h0);
        end
    endtask
    function automatic ubds_hs_t exp_hs(input logic [7:0] s, input logic in_dir, input logic pid);
        return !s[7] ? UBDS_HS_NAK : s[2] ? UBDS_HS_STALL :
            (!in_dir && s[3] && pid != s[6]) ? UBDS_HS_NONE : UBDS_HS_ACK;
    endfunction
    // ********
    // one token with its packet
    // ********
    task automatic run(input logic [7:0] s, input logic in_dir, input logic pid, input int n,
        input logic hold);
        logic [7:0] b;
        int h;
        ubds_hs_t e;
        b = 8'($urandom);
        if (!cur[7]) begin
            axw(ADDR_BD_STATUS, {24'h0, s});
            cur = s;
        end
        e = exp_hs(cur, in_dir, pid);
        h = host.hs_cnt;
        got_q = {};
        hold_buf <= hold;
        host.tok(in_dir, pid);
        fork
            if (!in_dir && cur[7] && !cur[2]) host.pkt(n, b, 1'($urandom));
            if (hold) begin
                repeat (30) @(posedge clk_sys);
                chk(host.hs_cnt - h, 0);
                hold_buf <= 1'b0;
            end
        join
        repeat (40) @(posedge clk_sys);
        chk(host.hs_cnt - h, 1);
        chk(32'(host.hs_last), 32'(e));
        if (e == UBDS_HS_ACK) begin
            cur = {1'b0, pid, 2'b00, cur[3:2], 2'b00};
            n_pkt += 1;
        end
        chk(got_q.size(), (e == UBDS_HS_ACK && !in_dir) ? n : 0);
        foreach (got_q[i]) chk(32'(got_q[i]), 32'(b + 8'(i)));
        axr(ADDR_BD_STATUS, {24'h0, cur}, 32'hcc);
        axr(ADDR_COUNT, n_pkt, 32'hffff_ffff);
    endtask
    initial begin
        {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, hold_buf, cur} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = '1;
        void'($urandom(53720));
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        axr(ADDR_BD_STATUS, 32'h0, 32'hcc);
        axr(ADDR_ENGINE, 32'h1, 32'hffff_ffff);
        axw(8'h0c, 32'hffff_ffff);
        axr(8'h0c, 32'h0, 32'hffff_ffff);
        run(8'h4c, 1'b1, 1'b1, 0, 1'b0);
        run(8'h0c, 1'b0, 1'b0, 4, 1'b0);
        run(8'hc8, 1'b0, 1'b1, 12, 1'b1);
        run(8'h88, 1'b0, 1'b1, 4, 1'b0);
        run(8'h88, 1'b0, 1'b0, 1, 1'b0);
        run(8'hc0, 1'b0, 1'b0, 3, 1'b0);
        repeat (8) run({1'($urandom), 1'($urandom), 2'b00, 1'($urandom), 3'b000},
            1'($urandom), 1'($urandom), 1 + $urandom % 8, 1'b0);
        run(8'h80, 1'b1, 1'b0, 0, 1'b0);
        run(8'h84, 1'b0, 1'b1, 2, 1'b0);
        run(8'h00, 1'b1, 1'b0, 0, 1'b0);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        cur = 8'h00;
        n_pkt = 0;
        run(8'hc0, 1'b1, 1'b1, 0, 1'b0);
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
